//--- design/sysctl_coproc_access_decoder.sv
// System-control coprocessor register access decoder with an APB register port.
// Assumes one pclk domain; abort events come from same-clock core logic.
`timescale 1ns/1ps

module sysctl_coproc_access_decoder #(
  parameter logic [31:0] ID_VALUE    = 32'h0000_0000,  // Arbitrary identity value
  parameter logic [31:0] CACHE_CFG   = 32'h0000_0000,
  parameter logic [31:0] VEND_STATUS = 32'h0000_0000,
  parameter logic [3:0]  REVISION    = 4'h1
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic [3:0]       cache_op,
  output logic [28:0]      cache_operand,
  output logic             cache_op_valid,
  output logic [2:0]       tlb_op,
  output logic [29:0]      tlb_operand,
  output logic             tlb_op_valid,
  output logic [31:0]      control_word
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [3:0]  regnum;
    logic        bank;
    logic [2:0]  aux;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        rd_ok;
    logic        wr_ok;
    logic [31:0] ctrl;
    logic [31:0] ttb;
    logic [31:0] dac;
    logic [31:0] fault_status_reg;
    logic [31:0] fault_address_reg;
    logic [31:0] dtlb_lk;
    logic [31:0] itlb_lk;
    logic [31:0] pid;
    logic [31:0] vcfg;
    logic [31:0] imax;
    logic [31:0] imin;
    logic [31:0] tid;
    logic [31:0] abt_addr;
    logic [3:0]  cop;
    logic [28:0] cop_arg;
    logic        cop_v;
    logic [2:0]  top;
    logic [29:0] top_arg;
    logic        top_v;
    logic [31:0] prdata;
  } state_s;

  state_s s_q;
  state_s s_d;

  // ****************************************************************
  // Access qualifiers
  // ****************************************************************
  logic wr_acc;
  logic rd_setup;
  logic cmd_hit;
  logic cmd_rd;
  logic cmd_wr;

  // Read data loads in the setup cycle, so it already stands at the access edge
  assign wr_acc   = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign cmd_hit  = wr_acc & (paddr == sysctl_pkg::ADDR_CMD);
  // A command with both bits set is a read
  assign cmd_rd   = cmd_hit & pwdata[sysctl_pkg::CMD_READ_BIT];
  assign cmd_wr   = cmd_hit & ~pwdata[sysctl_pkg::CMD_READ_BIT] &
                    pwdata[sysctl_pkg::CMD_WRITE_BIT];

  // ****************************************************************
  // Abort capture
  // ****************************************************************
  logic abt_fire;
  logic abt_data;

  // Only a fired data abort reaches the fault registers; instruction aborts are dropped
  assign abt_fire = wr_acc & (paddr == sysctl_pkg::ADDR_ABORT) &
                    pwdata[sysctl_pkg::ABT_FIRE_BIT];
  assign abt_data = abt_fire & pwdata[sysctl_pkg::ABT_DATA_BIT];

  // ****************************************************************
  // Coprocessor register read decode
  // ****************************************************************
  logic [31:0] rd_val;
  logic        rd_hit;

  // Aux select is looked at only for register 15
  always_comb begin
    rd_val = sysctl_pkg::RST_WORD;
    rd_hit = 1'b1;
    case (s_q.regnum)
      sysctl_pkg::CR_ID: begin
        if (!s_q.bank) begin
          rd_val = ID_VALUE;
        end else if (REVISION != 4'h0) begin
          rd_val = CACHE_CFG;
        end else begin
          rd_hit = 1'b0;
        end
      end
      sysctl_pkg::CR_CTRL:       rd_val = s_q.ctrl;
      sysctl_pkg::CR_TTB:        rd_val = s_q.ttb;
      sysctl_pkg::CR_DAC:        rd_val = s_q.dac;
      sysctl_pkg::CR_PID:        rd_val = s_q.pid;
      sysctl_pkg::CR_FAULT_STAT: rd_val = s_q.fault_status_reg;
      sysctl_pkg::CR_FAULT_ADDR: rd_val = s_q.fault_address_reg;
      sysctl_pkg::CR_TLBLK:      rd_val = s_q.bank ? s_q.itlb_lk : s_q.dtlb_lk;
      sysctl_pkg::CR_VEND: begin
        case (s_q.aux)
          sysctl_pkg::AUX_CFG:  rd_val = s_q.vcfg;
          sysctl_pkg::AUX_IMAX: rd_val = s_q.imax;
          sysctl_pkg::AUX_IMIN: rd_val = s_q.imin;
          sysctl_pkg::AUX_TID:  rd_val = s_q.tid;
          sysctl_pkg::AUX_STAT: rd_val = VEND_STATUS;
          default:              rd_hit = 1'b0;
        endcase
      end
      // Registers 7 and 8 are write-only; others are unmapped
      default: rd_hit = 1'b0;
    endcase
  end

  // ****************************************************************
  // Maintenance code decode
  // ****************************************************************
  logic [3:0] cop_code;
  logic       cop_hit;
  logic [2:0] top_code;
  logic       top_hit;

  // Operation chosen jointly by bank select and the low data bits
  always_comb begin
    cop_code = sysctl_pkg::COP_NONE;
    cop_hit  = 1'b1;
    case ({s_q.bank, s_q.wdata[2:0]})
      4'h8:    cop_code = sysctl_pkg::COP_INV_ALL;
      4'h9:    cop_code = sysctl_pkg::COP_INV_I;
      4'ha:    cop_code = sysctl_pkg::COP_INV_I_VA;
      4'hb:    cop_code = sysctl_pkg::COP_PREF_I;
      4'hc:    cop_code = sysctl_pkg::COP_DRAIN;
      4'h0:    cop_code = sysctl_pkg::COP_INV_D;
      4'h1:    cop_code = sysctl_pkg::COP_INV_D_VA;
      4'h2:    cop_code = sysctl_pkg::COP_INV_D_IDX;
      4'h3:    cop_code = sysctl_pkg::COP_CLN_D;
      4'h4:    cop_code = sysctl_pkg::COP_CLN_VA;
      4'h5:    cop_code = sysctl_pkg::COP_CI_VA;
      4'h6:    cop_code = sysctl_pkg::COP_CLN_IDX;
      4'h7:    cop_code = sysctl_pkg::COP_CI_IDX;
      default: cop_hit  = 1'b0;
    endcase
  end

  // Bank 1 code 3 and bank 0 codes 2 and 3 have no operation
  always_comb begin
    top_code = sysctl_pkg::TOP_NONE;
    top_hit  = 1'b1;
    case ({s_q.bank, s_q.wdata[1:0]})
      3'h4:    top_code = sysctl_pkg::TOP_INV_ALL;
      3'h5:    top_code = sysctl_pkg::TOP_INV_I;
      3'h6:    top_code = sysctl_pkg::TOP_INV_I_VA;
      3'h0:    top_code = sysctl_pkg::TOP_INV_D;
      3'h1:    top_code = sysctl_pkg::TOP_INV_D_VA;
      default: top_hit  = 1'b0;
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_d       = s_q;
    s_d.cop_v = 1'b0;
    s_d.top_v = 1'b0;
    if (rd_setup) begin
      case (paddr)
        sysctl_pkg::ADDR_REGNUM: s_d.prdata = {28'h0000000, s_q.regnum};
        sysctl_pkg::ADDR_SELECT: s_d.prdata = {25'h0000000, s_q.aux, 3'h0, s_q.bank};
        sysctl_pkg::ADDR_WDATA:  s_d.prdata = s_q.wdata;
        sysctl_pkg::ADDR_RDATA:  s_d.prdata = s_q.rdata;
        sysctl_pkg::ADDR_STATUS: s_d.prdata = {30'h00000000, s_q.wr_ok, s_q.rd_ok};
        sysctl_pkg::ADDR_ABORT:  s_d.prdata = s_q.abt_addr;
        default:                 s_d.prdata = sysctl_pkg::RST_WORD;
      endcase
    end
    if (wr_acc) begin
      case (paddr)
        sysctl_pkg::ADDR_REGNUM: s_d.regnum = pwdata[3:0];
        sysctl_pkg::ADDR_SELECT: begin
          s_d.bank = pwdata[sysctl_pkg::SEL_BANK_BIT];
          s_d.aux  = pwdata[sysctl_pkg::SEL_AUX_LSB +: 3];
        end
        sysctl_pkg::ADDR_WDATA:  s_d.wdata = pwdata;
        sysctl_pkg::ADDR_ABORT: begin
          if (abt_data) begin
            s_d.fault_status_reg  = {24'h000000, pwdata[sysctl_pkg::ABT_FS_LSB +: 8]};
            s_d.fault_address_reg = s_q.abt_addr;
          end
          if (!abt_fire) begin
            s_d.abt_addr = pwdata;
          end
        end
        sysctl_pkg::ADDR_CMD: begin
          s_d.rd_ok = 1'b0;
          s_d.wr_ok = 1'b0;
          if (cmd_rd) begin
            s_d.rd_ok = rd_hit;
            s_d.rdata = rd_val;
          end else if (cmd_wr) begin
            s_d.wr_ok = 1'b1;
            case (s_q.regnum)
              sysctl_pkg::CR_CTRL: s_d.ctrl = s_q.wdata;
              sysctl_pkg::CR_TTB:  s_d.ttb  = s_q.wdata;
              sysctl_pkg::CR_DAC:  s_d.dac  = s_q.wdata;
              sysctl_pkg::CR_PID:  s_d.pid  = s_q.wdata;
              sysctl_pkg::CR_FAULT_STAT: s_d.fault_status_reg  = s_q.wdata;
              sysctl_pkg::CR_FAULT_ADDR: s_d.fault_address_reg = s_q.wdata;
              sysctl_pkg::CR_TLBLK: begin
                if (!s_q.bank) begin
                  s_d.dtlb_lk = s_q.wdata;
                end else begin
                  s_d.wr_ok = 1'b0;
                end
              end
              sysctl_pkg::CR_CACHE: begin
                if (cop_hit) begin
                  s_d.cop     = cop_code;
                  s_d.cop_arg = s_q.wdata[31:3];
                  s_d.cop_v   = 1'b1;
                end else begin
                  s_d.wr_ok   = 1'b0;
                end
              end
              sysctl_pkg::CR_TLB: begin
                if (top_hit) begin
                  s_d.top     = top_code;
                  s_d.top_arg = s_q.wdata[31:2];
                  s_d.top_v   = 1'b1;
                end else begin
                  s_d.wr_ok   = 1'b0;
                end
              end
              sysctl_pkg::CR_VEND: begin
                case (s_q.aux)
                  sysctl_pkg::AUX_CFG:  s_d.vcfg = s_q.wdata;
                  sysctl_pkg::AUX_IMAX: s_d.imax = s_q.wdata;
                  sysctl_pkg::AUX_IMIN: s_d.imin = s_q.wdata;
                  sysctl_pkg::AUX_TID:  s_d.tid  = s_q.wdata;
                  default:              s_d.wr_ok = 1'b0;
                endcase
              end
              default: s_d.wr_ok = 1'b0;
            endcase
          end
        end
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Low clock enable freezes every field, the one-cycle pulses included
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Zero-wait slave that never signals an error
  assign pready         = 1'b1;
  assign pslverr        = 1'b0;
  assign prdata         = s_q.prdata;
  assign cache_op       = s_q.cop;
  assign cache_operand  = s_q.cop_arg;
  assign cache_op_valid = s_q.cop_v;
  assign tlb_op         = s_q.top;
  assign tlb_operand    = s_q.top_arg;
  assign tlb_op_valid   = s_q.top_v;
  assign control_word   = s_q.ctrl;

endmodule

//--- design/sysctl_pkg.sv
// Constants and types for the system-control register access decoder.
// Assumes a single APB clock domain; no other file depends on this beyond import by name.
package sysctl_pkg;

  // ****************************************************************
  // Register map (APB byte addresses)
  // ****************************************************************
  localparam logic [11:0] ADDR_REGNUM  = 12'h000;
  localparam logic [11:0] ADDR_SELECT  = 12'h004;
  localparam logic [11:0] ADDR_WDATA   = 12'h008;
  localparam logic [11:0] ADDR_CMD     = 12'h00c;
  localparam logic [11:0] ADDR_RDATA   = 12'h010;
  localparam logic [11:0] ADDR_STATUS  = 12'h014;
  localparam logic [11:0] ADDR_ABORT   = 12'h018;

  // ****************************************************************
  // Field positions and codes
  // ****************************************************************
  localparam int          SEL_BANK_BIT = 0;
  localparam int          SEL_AUX_LSB  = 4;
  localparam int          CMD_WRITE_BIT = 0;
  localparam int          CMD_READ_BIT  = 1;
  localparam int          ABT_FS_LSB    = 0;
  localparam int          ABT_DATA_BIT  = 8;
  localparam int          ABT_FIRE_BIT  = 9;

  localparam logic [3:0]  CR_ID    = 4'h0;
  localparam logic [3:0]  CR_CTRL  = 4'h1;
  localparam logic [3:0]  CR_TTB   = 4'h2;
  localparam logic [3:0]  CR_DAC   = 4'h3;
  localparam logic [3:0]  CR_FAULT_STAT = 4'h5;
  localparam logic [3:0]  CR_FAULT_ADDR = 4'h6;
  localparam logic [3:0]  CR_CACHE = 4'h7;
  localparam logic [3:0]  CR_TLB   = 4'h8;
  localparam logic [3:0]  CR_TLBLK = 4'ha;
  localparam logic [3:0]  CR_PID   = 4'hd;
  localparam logic [3:0]  CR_VEND  = 4'hf;

  localparam logic [2:0]  AUX_CFG  = 3'h0;
  localparam logic [2:0]  AUX_IMAX = 3'h1;
  localparam logic [2:0]  AUX_IMIN = 3'h2;
  localparam logic [2:0]  AUX_TID  = 3'h3;
  localparam logic [2:0]  AUX_STAT = 3'h4;

  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // Maintenance operation encodings driven out on cache_op / tlb_op
  typedef enum logic [3:0] {
    COP_NONE      = 4'h0,
    COP_INV_ALL   = 4'h1,
    COP_INV_I     = 4'h2,
    COP_INV_I_VA  = 4'h3,
    COP_PREF_I    = 4'h4,
    COP_DRAIN     = 4'h5,
    COP_INV_D     = 4'h6,
    COP_INV_D_VA  = 4'h7,
    COP_INV_D_IDX = 4'h8,
    COP_CLN_D     = 4'h9,
    COP_CLN_VA    = 4'ha,
    COP_CI_VA     = 4'hb,
    COP_CLN_IDX   = 4'hc,
    COP_CI_IDX    = 4'hd
  } cache_op_e;

  typedef enum logic [2:0] {
    TOP_NONE   = 3'h0,
    TOP_INV_ALL = 3'h1,
    TOP_INV_I  = 3'h2,
    TOP_INV_I_VA = 3'h3,
    TOP_INV_D  = 3'h4,
    TOP_INV_D_VA = 3'h5
  } tlb_op_e;

endpackage

//--- verif/sysctl_checker.sv
// Assertions on the decoder's command and operation ports.
// Assumes it is bound to sysctl_coproc_access_decoder and sees its ports only.
`timescale 1ns/1ps
module sysctl_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  cache_op,
  input wire logic [28:0] cache_operand,
  input wire logic        cache_op_valid,
  input wire logic [2:0]  tlb_op,
  input wire logic [29:0] tlb_operand,
  input wire logic        tlb_op_valid,
  input wire logic [31:0] control_word
);
  // ****************************************************************
  // Shadow of the command set-up registers
  // ****************************************************************
  logic [3:0]  reg_q;
  logic        bank_q;
  logic [31:0] dat_q;
  wire         acc    = psel && penable && pwrite && clk_en;
  wire         cmd_wr = acc && paddr == sysctl_pkg::ADDR_CMD && pwdata[1:0] == 2'b01;
  wire         ok7    = bank_q ? dat_q[2:0] <= 3'h4 : 1'b1;
  wire         ok8    = bank_q ? dat_q[1:0] != 2'h3 : !dat_q[1];
  wire [3:0]   cop_x  = (bank_q ? 4'h1 : 4'h6) + {1'b0, dat_q[2:0]};
  wire [2:0]   top_x  = (bank_q ? 3'h1 : 3'h4) + {1'b0, dat_q[1:0]};
  wire         is7    = cmd_wr && reg_q == sysctl_pkg::CR_CACHE;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_q  <= 4'h0;
      bank_q <= 1'b0;
      dat_q  <= 32'h0000_0000;
    end else if (acc) begin
      if (paddr == sysctl_pkg::ADDR_REGNUM) reg_q <= pwdata[3:0];
      if (paddr == sysctl_pkg::ADDR_SELECT) bank_q <= pwdata[0];
      if (paddr == sysctl_pkg::ADDR_WDATA) dat_q <= pwdata;
    end
  end
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_op7;  is7 && ok7; endsequence
  sequence s_bad7; is7 && !ok7; endsequence
  sequence s_op8;  cmd_wr && reg_q == sysctl_pkg::CR_TLB && ok8; endsequence
  a_cache_op_pick: assert property (s_op7 |=> cache_op_valid && cache_op == cop_x)
    else $error("cache operation code wrong");
  a_cache_operand: assert property (s_op7 |=> cache_operand == dat_q[31:3])
    else $error("cache operand wrong");
  a_cache_reject: assert property (s_bad7 |=> !cache_op_valid && $stable(cache_op))
    else $error("unassigned cache code acted");
  a_tlb_op_pick: assert property (s_op8 |=> tlb_op_valid && tlb_op == top_x)
    else $error("tlb operation code wrong");
  a_tlb_operand: assert property (s_op8 |=> tlb_operand == dat_q[31:2])
    else $error("tlb operand wrong");
  a_no_stray_op: assert property (!is7 |=> !cache_op_valid)
    else $error("cache pulse without command");
  a_ops_held: assert property (!cache_op_valid && !tlb_op_valid |->
    $stable(cache_op) && $stable(tlb_op))
    else $error("operation code moved without pulse");
  a_ctrl_load: assert property (cmd_wr && reg_q == sysctl_pkg::CR_CTRL |->
    ##1 control_word == dat_q)
    else $error("control word not loaded");
  a_pulse_single: assert property (cache_op_valid |=> !cache_op_valid)
    else $error("cache pulse too long");
endmodule

bind sysctl_coproc_access_decoder sysctl_checker sysctl_checker_i (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .cache_op(cache_op),
  .cache_operand(cache_operand), .cache_op_valid(cache_op_valid), .tlb_op(tlb_op),
  .tlb_operand(tlb_operand), .tlb_op_valid(tlb_op_valid), .control_word(control_word)
);

//--- verif/sysctl_coproc_access_decoder_tb.sv
// Self-checking bench for the coprocessor access decoder.
// Assumes the host model drives APB and the checker is bound to the design.
`timescale 1ns/1ps
module sysctl_coproc_access_decoder_tb;
  localparam logic [31:0] ID_V   = 32'h5a5a_0001; // Arbitrary identity value
  localparam logic [31:0] CFG_V  = 32'h0123_4567;
  localparam logic [31:0] STAT_V = 32'h0000_0c3c;
  logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic        cache_op_valid, tlb_op_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, control_word;
  logic [3:0]  cache_op;
  logic [28:0] cache_operand;
  logic [2:0]  tlb_op;
  logic [29:0] tlb_operand;
  int          fails, n_compared, n_cp, n_tp;

  sysctl_coproc_access_decoder #(.ID_VALUE(ID_V), .CACHE_CFG(CFG_V), .VEND_STATUS(STAT_V),
    .REVISION(4'h1)) sysctl_coproc_access_decoder_i (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cache_op(cache_op), .cache_operand(cache_operand), .cache_op_valid(cache_op_valid),
    .tlb_op(tlb_op), .tlb_operand(tlb_operand), .tlb_op_valid(tlb_op_valid),
    .control_word(control_word));
  sysctl_host_model sysctl_host_model_i (.pclk(pclk), .pready(pready), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (cache_op_valid === 1'b1) n_cp++;
    if (tlb_op_valid === 1'b1) n_tp++;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    logic ok;
    sysctl_host_model_i.xfer(w, a, d, q, ok);
    if (!ok) begin
      fails++;
      give_verdict();
    end
  endtask
  // Full register access: set up, command, then fetch result and status
  task automatic cop(input logic [3:0] r, input logic b, input logic [2:0] aux,
                     input logic [31:0] d, input logic [1:0] cmd,
                     output logic [31:0] q, output logic ok);
    logic [31:0] t;
    bus(1'b1, sysctl_pkg::ADDR_REGNUM, {28'h0, r}, t);
    bus(1'b1, sysctl_pkg::ADDR_SELECT, {25'h0, aux, 3'h0, b}, t);
    bus(1'b1, sysctl_pkg::ADDR_WDATA, d, t);
    bus(1'b1, sysctl_pkg::ADDR_CMD, {30'h0, cmd}, t);
    bus(1'b0, sysctl_pkg::ADDR_RDATA, 32'h0, q);
    bus(1'b0, sysctl_pkg::ADDR_STATUS, 32'h0, t);
    ok = cmd[1] ? t[0] : t[1];
  endtask
  // One maintenance code on register 7 or 8, expectation from the code tables
  task automatic op_case(input logic t8, input logic b, input logic [2:0] c);
    logic [31:0] d, q;
    logic        ok, good;
    logic [3:0]  e, prev;
    int          n0;
    d = $urandom();
    if (t8) d[1:0] = c[1:0];
    else d[2:0] = c;
    good = t8 ? (b ? c < 3 : c < 2) : (b ? c < 5 : 1'b1);
    e = t8 ? (b ? 4'h1 : 4'h4) + {1'b0, c} : (b ? 4'h1 : 4'h6) + {1'b0, c};
    prev = t8 ? {1'b0, tlb_op} : cache_op;
    n0 = t8 ? n_tp : n_cp;
    cop(t8 ? sysctl_pkg::CR_TLB : sysctl_pkg::CR_CACHE, b, d[6:4], d, 2'h1, q, ok);
    chk(32'((t8 ? n_tp : n_cp) - n0), {31'h0, good});
    chk({31'h0, ok}, {31'h0, good});
    chk({28'h0, t8 ? {1'b0, tlb_op} : cache_op}, {28'h0, good ? e : prev});
    if (good && t8) chk({tlb_operand, 2'b0}, {d[31:2], 2'b0});
    if (good && !t8) chk({cache_operand, 3'b0}, {d[31:3], 3'b0});
  endtask

  initial begin
    logic [31:0] d, q, t, rnd;
    logic [31:0] vd [4];
    logic        ok;
    logic [3:0]  r;
    logic [7:0]  fs;
    presetn = 1'b0;
    clk_en = 1'b1;
    fails = 0;
    n_compared = 0;
    n_cp = 0;
    n_tp = 0;
    void'($urandom(63997));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // ****************************************************************
    // Register 0, direct registers, lockdown and vendor group
    // ****************************************************************
    cop(sysctl_pkg::CR_ID, 1'b0, 3'h5, 32'h0, 2'h2, q, ok);
    chk(q, ID_V);
    cop(sysctl_pkg::CR_ID, 1'b1, 3'h0, 32'h0, 2'h2, q, ok);
    chk(q, CFG_V);
    cop(sysctl_pkg::CR_ID, 1'b0, 3'h0, 32'hffff_ffff, 2'h1, q, ok);
    chk({31'h0, ok}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      r = (i == 3) ? sysctl_pkg::CR_PID : 4'(i + 1);
      d = $urandom();
      rnd = $urandom();
      cop(r, rnd[0], rnd[6:4], d, 2'h1, q, ok);
      cop(r, rnd[1], rnd[10:8], 32'h0, 2'h2, q, ok);
      chk(q, d);
    end
    d = $urandom();
    cop(sysctl_pkg::CR_CTRL, 1'b1, 3'h7, d, 2'h1, q, ok);
    clk_en <= 1'b0;
    bus(1'b1, sysctl_pkg::ADDR_WDATA, ~d, t);
    clk_en <= 1'b1;
    bus(1'b1, sysctl_pkg::ADDR_CMD, 32'h1, t);
    chk(control_word, d);
    cop(sysctl_pkg::CR_TLBLK, 1'b0, 3'h6, d, 2'h1, q, ok);
    cop(sysctl_pkg::CR_TLBLK, 1'b0, 3'h0, 32'h0, 2'h2, q, ok);
    chk(q, d);
    cop(sysctl_pkg::CR_TLBLK, 1'b1, 3'h0, 32'h0, 2'h2, q, ok);
    chk(q, sysctl_pkg::RST_WORD);
    for (int a = 0; a < 4; a++) begin
      vd[a] = $urandom();
      cop(sysctl_pkg::CR_VEND, vd[a][0], 3'(a), vd[a], 2'h1, q, ok);
    end
    for (int a = 0; a < 5; a++) begin
      cop(sysctl_pkg::CR_VEND, 1'b0, 3'(a), 32'h0, 2'h2, q, ok);
      chk(q, (a == 4) ? STAT_V : vd[a]);
    end
    cop(sysctl_pkg::CR_VEND, 1'b0, 3'h4, d, 2'h1, q, ok);
    chk({31'h0, ok}, 32'h0);
    $display("test registers done");
    // ****************************************************************
    // Aborts, then every maintenance code under both bank selects
    // ****************************************************************
    d = $urandom() & 32'hffff_fdff;
    fs = 8'($urandom());
    bus(1'b1, sysctl_pkg::ADDR_ABORT, d, t);
    bus(1'b1, sysctl_pkg::ADDR_ABORT, {22'h0, 2'b11, fs}, t);
    bus(1'b1, sysctl_pkg::ADDR_ABORT, ~d & 32'hffff_fdff, t);
    bus(1'b1, sysctl_pkg::ADDR_ABORT, {22'h0, 2'b10, ~fs}, t);
    cop(sysctl_pkg::CR_FAULT_STAT, 1'b1, 3'h2, 32'h0, 2'h2, q, ok);
    chk(q, {24'h0, fs});
    cop(sysctl_pkg::CR_FAULT_ADDR, 1'b1, 3'h2, 32'h0, 2'h2, q, ok);
    chk(q, d);
    $display("test aborts done");
    for (int b = 0; b < 2; b++) begin
      for (int c = 0; c < 8; c++) begin
        op_case(1'b0, b[0], c[2:0]);
        if (c < 4) op_case(1'b1, b[0], c[2:0]);
      end
    end
    cop(sysctl_pkg::CR_CACHE, 1'b0, 3'h0, 32'h0, 2'h2, q, ok);
    chk({31'h0, ok}, 32'h0);
    $display("test maintenance done");
    give_verdict();
  end
endmodule

//--- verif/sysctl_host_model.sv
// Debug host model: an APB master issuing register reads and writes.
// Assumes read data stands at the edge where pready is sampled high.
`timescale 1ns/1ps
module sysctl_host_model (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  // Entered just after a rising edge; returns one edge after the release
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic ok);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    ok = pready === 1'b1;
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge pclk);
  endtask
endmodule
